// ==== sofc_defs.svh ====
// Register map, field positions, reset values and timing counts
`ifndef SOFC_DEFS_SVH
`define SOFC_DEFS_SVH

`define SOFC_A_PSKEW 16'h0D1B
`define SOFC_A_SSKEW 16'h0D2B
`define SOFC_A_TOFS 16'h0D30
`define SOFC_A_SLEW 16'h0D34
`define SOFC_A_LAT 16'h0D37
`define SOFC_A_MAG 16'h0D39
`define SOFC_A_STAT 16'h0D40
`define SOFC_A_RESTART 16'h0F08
`define SOFC_A_TAG 16'h0F09
`define SOFC_A_TIME0 16'h0F0A
`define SOFC_A_TIME1 16'h0F0E
`define SOFC_A_TIME2 16'h0F12
`define SOFC_A_IOUPD 16'h000F
`define SOFC_A_EVT 16'h301D

`define SOFC_B_READY 2
`define SOFC_B_SLEWING 6
`define SOFC_B_ERR 7
`define SOFC_B_EVT_ERR 1
`define SOFC_B_EVT_SLEW_ON 2
`define SOFC_B_EVT_SLEW_OFF 3
`define SOFC_B_RESTART 0
`define SOFC_B_IOUPD 0

`define SOFC_TAG_PRI 5'h10
`define SOFC_TAG_SEC 5'h11
`define SOFC_TAG_HI 8'h30

`define SOFC_RST_SKEW 24'h000000
`define SOFC_RST_TOFS 32'h00000000
`define SOFC_RST_SLEW 24'h000000
`define SOFC_RST_LAT 16'h0000
`define SOFC_RST_MAG 20'h00000

`define SOFC_MAG_SHIFT 8
`define SOFC_CLK_PERIOD_PS 64'd5000
`define SOFC_LAT_UNIT_PS 64'd15258789
`define SOFC_LAT_CYC 12'(`SOFC_LAT_UNIT_PS / `SOFC_CLK_PERIOD_PS)
`define SOFC_SLEW_GAIN \
  18'((64'd1 << 44) * `SOFC_CLK_PERIOD_PS / 64'd1000000000000)

`endif

// ==== sofc_pkg.sv ====
// Types shared by the offset conditioner modules
package sofc_pkg;

  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_PEND = 3'b010,
    ST_CHECK = 3'b100
  } sofc_state_t;

  typedef struct packed {
    sofc_state_t st;
    logic [23:0] pskew;
    logic [23:0] sskew;
    logic [31:0] tofs;
    logic [23:0] slew;
    logic [15:0] lat;
    logic [19:0] mag;
    logic [4:0] tag;
    logic [95:0] wtime;
    logic [95:0] cap;
    logic [63:0] smp;
    logic smp_vld;
    logic [11:0] pre;
    logic [15:0] latcnt;
    logic ready;
    logic err;
    logic skip_mag;
    logic init_first;
    logic restart;
    logic stall;
    logic slew_prev;
    logic [3:1] evt;
    logic [31:0] rdata;
  } sofc_top_st_t;

endpackage : sofc_pkg

// ==== sofc_path_if.sv ====
// Offset path between control, refinement and slew limiter
`timescale 1ns/10ps
interface sofc_path_if #(
  parameter int W = 64
);
  logic rst_hold;
  logic smp_vld;
  logic [W-1:0] smp;
  logic ref_vld;
  logic [W-1:0] ref_val;
  logic [23:0] slew_lim;
  logic slew_stall;
  logic slew_byp;
  logic slew_hold;
  logic [W-1:0] out_val;
  logic slewing;

  modport ctl (
    output rst_hold, smp_vld, smp, slew_lim, slew_stall, slew_byp,
    output slew_hold,
    input ref_vld, out_val, slewing
  );
  modport refine (
    input rst_hold, smp_vld, smp,
    output ref_vld, ref_val
  );
  modport slew (
    input ref_vld, ref_val, slew_lim, slew_stall, slew_byp, slew_hold,
    output out_val, slewing
  );
endinterface : sofc_path_if

// ==== sofc_refine.sv ====
// Progressive offset refinement filter
`timescale 1ns/10ps
`include "sofc_defs.svh"
module sofc_refine
  import sofc_pkg::*;
#(
  parameter int W = 64,
  parameter int MAX_SHIFT = 4
) (
  // Clock and control
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  // Offset path
  sofc_path_if.refine pif
);
  typedef struct packed {
    logic [3:0] shift;
    logic vld;
    logic [W-1:0] acc;
  } sofc_ref_st_t;

  sofc_ref_st_t r;
  sofc_ref_st_t next_r;

  generate
    if (MAX_SHIFT < 1 || MAX_SHIFT > 15 || W < 48)
    begin : g_bad
      $error("sofc_refine: unsupported parameters");
    end
  endgenerate

  always_comb
  begin
    next_r = r;
    next_r.vld = 1'b0;
    if (pif.rst_hold)
    begin
      next_r.shift = 4'h0;
    end
    if (pif.smp_vld)
    begin
      if (next_r.shift == 4'h0)
      begin
        next_r.acc = pif.smp;
      end
      else
      begin
        next_r.acc = r.acc + W'($signed(pif.smp - r.acc) >>> next_r.shift);
      end
      next_r.vld = 1'b1;
      if (next_r.shift < 4'(MAX_SHIFT))
      begin
        next_r.shift = next_r.shift + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      r <= '0;
    end
    else if (ce_in)
    begin
      r <= next_r;
    end
  end

  assign pif.ref_vld = r.vld;
  assign pif.ref_val = r.acc;
endmodule : sofc_refine

// ==== sofc_slew.sv ====
// Slew limiter ahead of the common time scale
`timescale 1ns/10ps
`include "sofc_defs.svh"
module sofc_slew
  import sofc_pkg::*;
#(
  parameter int W = 64
) (
  // Clock and control
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  // Offset path
  sofc_path_if.slew pif
);
  typedef struct packed {
    logic [W-1:0] cur;
    logic [W-1:0] tgt;
    logic [31:0] frac;
    logic slewing;
  } sofc_slew_st_t;

  sofc_slew_st_t r;
  sofc_slew_st_t next_r;
  logic [63:0] inc;
  logic [W-1:0] diff;
  logic [W-1:0] mag;
  logic [W-1:0] step;

  generate
    if (W < 48 || W > 96)
    begin : g_bad
      $error("sofc_slew: unsupported width");
    end
  endgenerate

  always_comb
  begin
    next_r = r;
    inc = {32'h0, r.frac} + 64'(pif.slew_lim) * 64'(`SOFC_SLEW_GAIN);
    diff = r.tgt - r.cur;
    mag = diff[W-1] ? -diff : diff;
    step = W'(inc[63:32]);
    if (pif.slew_hold)
    begin
      next_r.tgt = r.cur;
      next_r.frac = 32'h0;
    end
    else
    begin
      if (pif.ref_vld)
      begin
        next_r.tgt = pif.ref_val;
      end
      if (pif.ref_vld && pif.slew_byp)
      begin
        next_r.cur = pif.ref_val;
      end
      else if (pif.slew_lim == 24'h0)
      begin
        next_r.cur = next_r.tgt;
      end
      else if (!pif.slew_stall && r.cur != r.tgt)
      begin
        next_r.frac = inc[31:0];
        if (mag <= step)
        begin
          next_r.cur = r.tgt;
        end
        else if (diff[W-1])
        begin
          next_r.cur = r.cur - step;
        end
        else
        begin
          next_r.cur = r.cur + step;
        end
      end
    end
    if (next_r.cur == next_r.tgt)
    begin
      next_r.frac = 32'h0;
    end
    next_r.slewing = next_r.cur != next_r.tgt;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      r <= '0;
    end
    else if (ce_in)
    begin
      r <= next_r;
    end
  end

  assign pif.out_val = r.cur;
  assign pif.slewing = r.slewing;
endmodule : sofc_slew

// ==== sofc_top.sv ====
// Synchronization offset conditioner top level
// Behaviour
// - Separate signed 24-bit primary and secondary skews
// - Add skew of the active path
// - Add shared signed 32-bit time offset
// - First offset after restart passes unfiltered
// - Later offsets filtered progressively harder, bounded
// - Magnitude check only with nonzero threshold
// - Oversize offset raises guard, kept out
// - Check skips first event after restart/init
// - Threshold unsigned 20-bit, 2^-40 s steps
// - Missing time within latency limit: discard, guard after initial sync
// - Latency limit 16-bit, 2^-16 s, zero disables
// - Slew limiter follows refinement, feeds output
// - Phase steps become constant-slope ramps
// - Slew limit 24-bit, nonzero enables limiter
// - Zero slew limit bypasses limiter anytime
// - First offset after initial sync bypasses limiter
// - Limiter pauses briefly on new limit
// - Status bit 6 shows ramping
// - Event bits 2/3 mark ramp start/end
// - Restart does not bypass the limiter
// - Guard event sets error, status bit 7
// - Before initial sync, stages held reset
// - Switchover flushes capture, keeps filter and limiter
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`include "sofc_defs.svh"
module sofc_top
  import sofc_pkg::*;
#(
  parameter int FILT_MAX_SHIFT = 4
) (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  // Register port
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Synchronization source
  input wire logic sync_event_in,
  input wire logic [95:0] event_time_in,
  input wire logic secondary_active_in,
  input wire logic switchover_in,
  input wire logic sys_pll_stable_in,
  // Common time scale and status
  output logic [63:0] offset_out,
  output logic ready_out,
  output logic sync_err_out,
  output logic slewing_out
);
  sofc_top_st_t r;
  sofc_top_st_t next_r;
  logic wr_io;
  logic tag_ok;
  logic [23:0] skew;
  logic [63:0] new_ofs;
  logic [63:0] abs_ofs;
  logic [63:0] thr;
  logic too_big;
  logic guard;
  logic clr_err;
  logic lat_out;
  logic [3:1] evt_set;

  sofc_path_if #(.W(64)) pif ();

  generate
    if (FILT_MAX_SHIFT < 1 || FILT_MAX_SHIFT > 15)
    begin : g_bad
      $error("sofc_top: unsupported filter depth");
    end
  endgenerate

  always_comb
  begin
    next_r = r;
    next_r.rdata = 32'h0;
    next_r.smp_vld = 1'b0;
    next_r.restart = 1'b0;
    next_r.stall = 1'b0;
    guard = 1'b0;
    clr_err = 1'b0;
    lat_out = 1'b0;
    wr_io = reg_wr_in && reg_addr_in == `SOFC_A_IOUPD
      && reg_wdata_in[`SOFC_B_IOUPD];
    tag_ok = r.tag == (secondary_active_in ? `SOFC_TAG_SEC : `SOFC_TAG_PRI);
    skew = secondary_active_in ? r.sskew : r.pskew;
    new_ofs = r.wtime[63:0] + {{40{skew[23]}}, skew}
      + {{32{r.tofs[31]}}, r.tofs} - r.cap[63:0];
    abs_ofs = r.smp[63] ? -r.smp : r.smp;
    thr = {36'h0, r.mag, 8'h00};
    too_big = r.mag != `SOFC_RST_MAG && !r.skip_mag && abs_ofs > thr;

    // Register writes
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        `SOFC_A_PSKEW: next_r.pskew = reg_wdata_in[23:0];
        `SOFC_A_SSKEW: next_r.sskew = reg_wdata_in[23:0];
        `SOFC_A_TOFS: next_r.tofs = reg_wdata_in;
        `SOFC_A_SLEW:
        begin
          next_r.slew = reg_wdata_in[23:0];
          next_r.stall = 1'b1;
        end
        `SOFC_A_LAT: next_r.lat = reg_wdata_in[15:0];
        `SOFC_A_MAG: next_r.mag = reg_wdata_in[19:0];
        `SOFC_A_RESTART: next_r.restart = reg_wdata_in[`SOFC_B_RESTART];
        `SOFC_A_TAG:
        begin
          next_r.tag = {reg_wdata_in[7:5], 5'h00}
            == (`SOFC_TAG_HI & 8'hE0) ? reg_wdata_in[4:0] : 5'h00;
        end
        `SOFC_A_TIME0: next_r.wtime[31:0] = reg_wdata_in;
        `SOFC_A_TIME1: next_r.wtime[63:32] = reg_wdata_in;
        `SOFC_A_TIME2: next_r.wtime[95:64] = reg_wdata_in;
        default:
        begin
        end
      endcase
    end

    // Register reads
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `SOFC_A_PSKEW: next_r.rdata = {8'h00, r.pskew};
        `SOFC_A_SSKEW: next_r.rdata = {8'h00, r.sskew};
        `SOFC_A_TOFS: next_r.rdata = r.tofs;
        `SOFC_A_SLEW: next_r.rdata = {8'h00, r.slew};
        `SOFC_A_LAT: next_r.rdata = {16'h0000, r.lat};
        `SOFC_A_MAG: next_r.rdata = {12'h000, r.mag};
        `SOFC_A_TAG: next_r.rdata = {27'h0, r.tag};
        `SOFC_A_TIME0: next_r.rdata = r.wtime[31:0];
        `SOFC_A_TIME1: next_r.rdata = r.wtime[63:32];
        `SOFC_A_TIME2: next_r.rdata = r.wtime[95:64];
        `SOFC_A_STAT:
        begin
          next_r.rdata[`SOFC_B_READY] = r.ready;
          next_r.rdata[`SOFC_B_SLEWING] = pif.slewing;
          next_r.rdata[`SOFC_B_ERR] = r.err;
        end
        `SOFC_A_EVT: next_r.rdata = {28'h0, r.evt, 1'b0};
        default: next_r.rdata = 32'h0;
      endcase
    end

    // Latency prescaler
    if (r.st == ST_PEND && r.lat != `SOFC_RST_LAT)
    begin
      if (r.pre == `SOFC_LAT_CYC - 12'd1)
      begin
        next_r.pre = 12'h000;
        next_r.latcnt = r.latcnt + 16'h0001;
        lat_out = next_r.latcnt >= r.lat;
      end
      else
      begin
        next_r.pre = r.pre + 12'h001;
      end
    end

    // Event sequencing
    unique case (r.st)
      ST_WAIT:
      begin
        if (wr_io && tag_ok && r.ready)
        begin
          guard = 1'b1;
        end
      end
      ST_PEND:
      begin
        if (wr_io && tag_ok)
        begin
          next_r.smp = new_ofs;
          next_r.st = ST_CHECK;
        end
        else if (lat_out)
        begin
          next_r.st = ST_WAIT;
          guard = r.ready;
        end
      end
      ST_CHECK:
      begin
        next_r.st = ST_WAIT;
        if (wr_io && tag_ok && r.ready)
        begin
          guard = 1'b1;
        end
        if (r.ready && too_big)
        begin
          guard = 1'b1;
        end
        else if (!r.ready && !sys_pll_stable_in)
        begin
          next_r.st = ST_WAIT;
        end
        else
        begin
          next_r.smp_vld = 1'b1;
          clr_err = 1'b1;
          next_r.skip_mag = !r.ready;
          if (!r.ready)
          begin
            next_r.ready = 1'b1;
            next_r.init_first = 1'b1;
          end
        end
      end
      default:
      begin
        next_r.st = ST_WAIT;
      end
    endcase

    if (switchover_in)
    begin
      next_r.st = ST_WAIT;
    end
    if (sync_event_in)
    begin
      next_r.cap = event_time_in;
      next_r.st = ST_PEND;
      next_r.pre = 12'h000;
      next_r.latcnt = 16'h0000;
    end

    if (r.restart)
    begin
      next_r.skip_mag = 1'b1;
    end
    if (pif.ref_vld)
    begin
      next_r.init_first = 1'b0;
    end

    next_r.err = (r.err && !clr_err) || guard;
    next_r.slew_prev = pif.slewing;
    evt_set[`SOFC_B_EVT_ERR] = guard;
    evt_set[`SOFC_B_EVT_SLEW_ON] = pif.slewing && !r.slew_prev;
    evt_set[`SOFC_B_EVT_SLEW_OFF] = !pif.slewing && r.slew_prev;
    if (reg_wr_in && reg_addr_in == `SOFC_A_EVT)
    begin
      next_r.evt = (r.evt & ~reg_wdata_in[3:1]) | evt_set;
    end
    else
    begin
      next_r.evt = r.evt | evt_set;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (sys_rst_in)
    begin
      r <= '0;
      r.st <= ST_WAIT;
      r.pskew <= `SOFC_RST_SKEW;
      r.sskew <= `SOFC_RST_SKEW;
      r.tofs <= `SOFC_RST_TOFS;
      r.slew <= `SOFC_RST_SLEW;
      r.lat <= `SOFC_RST_LAT;
      r.mag <= `SOFC_RST_MAG;
    end
    else if (ce_in)
    begin
      r <= next_r;
    end
  end

  assign pif.rst_hold = !r.ready || r.restart;
  assign pif.slew_hold = !r.ready;
  assign pif.smp_vld = r.smp_vld;
  assign pif.smp = r.smp;
  assign pif.slew_lim = r.slew;
  assign pif.slew_stall = r.stall;
  assign pif.slew_byp = r.init_first;

  sofc_refine #(
    .W(64),
    .MAX_SHIFT(FILT_MAX_SHIFT)
  ) u_refine (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .pif(pif.refine)
  );

  sofc_slew #(
    .W(64)
  ) u_slew (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .pif(pif.slew)
  );

  assign reg_rdata_out = r.rdata;
  assign offset_out = pif.out_val;
  assign ready_out = r.ready;
  assign sync_err_out = r.err;
  assign slewing_out = pif.slewing;
endmodule : sofc_top

// ==== sofc_top_chk.sv ====
// Port-level checker for the offset conditioner
`timescale 1ns/10ps
`include "sofc_defs.svh"
module sofc_top_chk
  import sofc_pkg::*;
#(
  parameter int FILT_MAX_SHIFT = 4
) (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  // Register port
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // Synchronization source
  input wire logic sync_event_in,
  input wire logic [95:0] event_time_in,
  input wire logic secondary_active_in,
  input wire logic switchover_in,
  input wire logic sys_pll_stable_in,
  // Outputs watched
  input wire logic [63:0] offset_out,
  input wire logic ready_out,
  input wire logic sync_err_out,
  input wire logic slewing_out
);
  logic ioupd_w;
  logic slw_wr;
  assign ioupd_w = reg_wr_in && reg_addr_in == `SOFC_A_IOUPD
    && reg_wdata_in[0];
  assign slw_wr = reg_wr_in && reg_addr_in == `SOFC_A_SLEW;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_stat_rd;
    reg_rd_in && reg_addr_in == `SOFC_A_STAT;
  endsequence
  sequence s_rst_rd;
    reg_rd_in && reg_addr_in == `SOFC_A_RESTART;
  endsequence
  sequence s_slew_off;
    slw_wr && reg_wdata_in[23:0] == 24'h000000;
  endsequence
  property p_stat;
    s_stat_rd |=> reg_rdata_out[7:6] == {$past(sync_err_out),
      $past(slewing_out)} && reg_rdata_out[2] == $past(ready_out);
  endproperty
  property p_rst_rd;
    s_rst_rd |=> reg_rdata_out == 32'h00000000;
  endproperty
  property p_err_ready;
    $rose(sync_err_out) |-> $past(ready_out);
  endproperty
  property p_hold_off;
    !ready_out |-> offset_out == 64'h0000000000000000;
  endproperty
  property p_ready_keep;
    ready_out |=> ready_out;
  endproperty
  property p_slew_zero;
    s_slew_off |-> ##[1:4] !slewing_out;
  endproperty
  property p_cause;
    $changed(offset_out) && !slewing_out && !$past(slewing_out)
      && !$past(slewing_out, 2) |-> $past(ioupd_w, 4);
  endproperty
  property p_rate;
    slewing_out && $past(slewing_out) && !$past(slw_wr)
      && !$past(slw_wr, 2) && !$past(slw_wr, 3)
      |-> $signed(offset_out - $past(offset_out)) <= 64'sd400
      && $signed(offset_out - $past(offset_out)) >= -64'sd400;
  endproperty
  a_stat: assert property (p_stat) else $error("status bits wrong");
  a_rst_rd: assert property (p_rst_rd) else $error("restart read");
  a_err_ready: assert property (p_err_ready) else $error("early err");
  a_hold_off: assert property (p_hold_off) else $error("early ofs");
  a_ready_keep: assert property (p_ready_keep) else $error("rdy lost");
  a_slew_zero: assert property (p_slew_zero) else $error("no bypass");
  a_cause: assert property (p_cause) else $error("offset moved");
  a_rate: assert property (p_rate) else $error("slope too steep");
endmodule : sofc_top_chk

bind sofc_top sofc_top_chk #(.FILT_MAX_SHIFT(FILT_MAX_SHIFT)) u_chk (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .sync_event_in(sync_event_in),
  .event_time_in(event_time_in),
  .secondary_active_in(secondary_active_in),
  .switchover_in(switchover_in), .sys_pll_stable_in(sys_pll_stable_in),
  .offset_out(offset_out), .ready_out(ready_out),
  .sync_err_out(sync_err_out), .slewing_out(slewing_out)
);

// ==== sofc_top_tb.sv ====
// Self-checking bench for the offset conditioner
`timescale 1ns/10ps
`include "sofc_defs.svh"
module sofc_top_tb;
  import sofc_pkg::*;
  localparam logic [23:0] PSK = 24'hEA8671;
  localparam logic [23:0] SSK = 24'h001234;
  localparam logic [31:0] TOF = 32'h00D6BF95;
  localparam logic [15:0] RA [6] = '{`SOFC_A_PSKEW, `SOFC_A_SSKEW,
    `SOFC_A_TOFS, `SOFC_A_SLEW, `SOFC_A_LAT, `SOFC_A_MAG};
  localparam logic [31:0] RM [6] = '{32'h00FFFFFF, 32'h00FFFFFF,
    32'hFFFFFFFF, 32'h00FFFFFF, 32'h0000FFFF, 32'h000FFFFF};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [15:0] addr;
  logic [31:0] wd, rdat, v;
  logic wstb, rstb, ev, sw, sec, pll, rdy, err, slw;
  logic [95:0] etime;
  logic [95:0] cap = 96'h0;
  logic [63:0] offs, cur, tgt;
  int error_cnt = 0;
  int checks = 0;

  sofc_top #(.FILT_MAX_SHIFT(4)) dut (
    .sys_clk_in(clk), .sys_rst_in(rst), .ce_in(ce),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wstb),
    .reg_rd_in(rstb), .reg_rdata_out(rdat), .sync_event_in(ev),
    .event_time_in(etime), .secondary_active_in(sec),
    .switchover_in(sw), .sys_pll_stable_in(pll), .offset_out(offs),
    .ready_out(rdy), .sync_err_out(err), .slewing_out(slw)
  );

  initial forever #2.5 clk = ~clk;

  task automatic chk(input string n, input logic [63:0] e,
    input logic [63:0] g);
    checks++;
    if (e !== g)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wreg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wstb <= 1'b1;
    @(posedge clk);
    wstb <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rstb <= 1'b1;
    @(posedge clk);
    rstb <= 1'b0;
    #1;
    d = rdat;
  endtask : rreg

  function automatic logic [63:0] expo(input logic [63:0] d,
    input logic s);
    logic [23:0] sk;
    sk = s ? SSK : PSK;
    return d + {{40{sk[23]}}, sk} + {{32{TOF[31]}}, TOF};
  endfunction : expo

  task automatic pulse_event;
    @(posedge clk);
    ev <= 1'b1;
    etime <= cap;
    @(posedge clk);
    ev <= 1'b0;
  endtask : pulse_event

  task automatic sync(input logic [63:0] d, input logic s,
    input logic dosw);
    logic [95:0] t;
    cap = cap + 96'h000000000001000000000000;
    t = cap + {32'h0, d};
    pulse_event();
    sw <= dosw;
    @(posedge clk);
    sw <= 1'b0;
    wreg(`SOFC_A_TIME0, t[31:0]);
    wreg(`SOFC_A_TIME1, t[63:32]);
    wreg(`SOFC_A_TIME2, t[95:64]);
    wreg(`SOFC_A_TAG, {24'h0, `SOFC_TAG_HI} | {31'h0, s});
    wreg(`SOFC_A_IOUPD, 32'h00000001);
    repeat (4) @(posedge clk);
    #1;
  endtask : sync

  task automatic stop_test;
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  initial
  begin
    {wstb, rstb, ev, sw, sec} = 5'h00;
    addr = 16'h0000;
    wd = 32'h00000000;
    etime = 96'h0;
    pll = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      rreg(RA[i], v);
      chk("reset value", 64'h0, v);
      wreg(RA[i], 32'hFFFFFFFF);
      rreg(RA[i], v);
      chk("field width", RM[i], v);
      wreg(RA[i], 32'h00000000);
    end
    ce <= 1'b0;
    wreg(`SOFC_A_PSKEW, 32'h00000055);
    ce <= 1'b1;
    rreg(`SOFC_A_PSKEW, v);
    chk("clock enable", 64'h0, v);
    wreg(`SOFC_A_PSKEW, {8'h00, PSK});
    wreg(`SOFC_A_SSKEW, {8'h00, SSK});
    wreg(`SOFC_A_TOFS, TOF);
    wreg(16'h0D41, 32'hFFFFFFFF);
    rreg(16'h0D41, v);
    chk("unmapped", 64'h0, v);
    rreg(`SOFC_A_RESTART, v);
    chk("restart read", 64'h0, v);
    chk("offset before ready", 64'h0, offs);
    sync(64'd1000, 1'b0, 1'b0);
    chk("first offset", expo(64'd1000, 1'b0), offs);
    chk("ready", 64'h1, rdy);
    @(posedge clk);
    sec <= 1'b1;
    wreg(`SOFC_A_RESTART, 32'h00000001);
    sync(64'd5000, 1'b1, 1'b0);
    chk("secondary", expo(64'd5000, 1'b1), offs);
    cur = offs;
    @(posedge clk);
    sec <= 1'b0;
    sync(64'd9000000, 1'b0, 1'b0);
    tgt = expo(64'd9000000, 1'b0);
    chk("filtered", 64'h1, {63'h0, $signed(offs - cur) > 0
      && $signed(tgt - offs) > 0});
    wreg(`SOFC_A_MAG, 32'h00000001);
    cur = offs;
    sync(64'd2000000, 1'b0, 1'b0);
    chk("guard error", 64'h1, err);
    chk("offset held", cur, offs);
    rreg(`SOFC_A_STAT, v);
    chk("status error", 64'h1, v[7]);
    rreg(`SOFC_A_EVT, v);
    chk("guard event", 64'h1, v[1]);
    wreg(`SOFC_A_MAG, 32'h00000000);
    sync(64'd2000000, 1'b0, 1'b0);
    chk("check off", 64'h0, err);
    wreg(`SOFC_A_LAT, 32'h00000001);
    pulse_event();
    repeat (3045) @(posedge clk);
    #1;
    chk("latency early", 64'h0, err);
    repeat (35) @(posedge clk);
    #1;
    chk("latency guard", 64'h1, err);
    wreg(`SOFC_A_LAT, 32'h00000000);
    wreg(`SOFC_A_RESTART, 32'h00000001);
    sync(64'd3000, 1'b0, 1'b0);
    cur = expo(64'd3000, 1'b0);
    chk("restart offset", cur, offs);
    sync(64'd4000, 1'b0, 1'b1);
    chk("switchover flush", 64'h1, err);
    chk("offset kept", cur, offs);
    wreg(`SOFC_A_EVT, 32'h0000000E);
    wreg(`SOFC_A_SLEW, 32'h00FFFFFF);
    wreg(`SOFC_A_RESTART, 32'h00000001);
    sync(64'd103000, 1'b0, 1'b0);
    chk("ramping", 64'h1, slw);
    rreg(`SOFC_A_STAT, v);
    chk("status ramp", 64'h1, v[6]);
    repeat (20) @(posedge clk);
    #1;
    tgt = expo(64'd103000, 1'b0);
    chk("partial ramp", 64'h1, {63'h0, $signed(offs - cur) > 0
      && $signed(tgt - offs) > 0});
    wreg(`SOFC_A_SLEW, 32'h00000000);
    repeat (6) @(posedge clk);
    #1;
    chk("bypass stop", 64'h0, slw);
    chk("bypass value", tgt, offs);
    rreg(`SOFC_A_EVT, v);
    chk("ramp events", 64'h3, v[3:2]);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    pll <= 1'b0;
    sync(64'd500, 1'b0, 1'b0);
    chk("unstable ready", 64'h0, rdy);
    chk("unstable offset", 64'h0, offs);
    pll <= 1'b1;
    wreg(`SOFC_A_SLEW, 32'h00000001);
    sync(64'd500, 1'b0, 1'b0);
    chk("initial bypass", 64'd500, offs);
    chk("bypass no ramp", 64'h0, slw);
    chk("stable ready", 64'h1, rdy);
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule : sofc_top_tb
